// ===== halfword_load_consts.vh
`ifndef HALFWORD_LOAD_CONSTS_VH
`define HALFWORD_LOAD_CONSTS_VH

// Instruction word fields, bit 0 of the format is bit 31 here
`define PRIMARY_HI        31
`define PRIMARY_LO        26
`define TARGET_HI         25
`define TARGET_LO         21
`define BASE_HI           20
`define BASE_LO           16
`define INDEX_HI          15
`define INDEX_LO          11
`define EXTOP_HI          10
`define EXTOP_LO          1
`define IMM_HI            15
`define IMM_LO            0

// Opcodes
`define OP_INDEXED_GROUP  6'h1F
`define OP_UNSIGNED_DISP  6'h28
`define OP_UNSIGNED_UPD   6'h29
`define XO_SIGNED_IDX     10'h157
`define XO_SWAPPED_IDX    10'h316
`define XO_UNSIGNED_UPD   10'h14B
`define XO_UNSIGNED_IDX   10'h117

// Extension kinds
`define EXT_ZERO          2'h0
`define EXT_SIGN          2'h1
`define EXT_SWAP          2'h2

`define REG_ZERO          5'h00

`endif

// ===== halfword_load_unit.v
`timescale 1ns/1ps
`include "halfword_load_consts.vh"

module halfword_load_unit (
   input  wire        I_CLK,
   input  wire        I_RST,
   input  wire        I_INSN_VALID,
   input  wire [31:0] I_INSN,
   input  wire [31:0] I_GPR_RDATA_A,
   input  wire [31:0] I_GPR_RDATA_B,
   input  wire        I_MEM_ACK,
   input  wire [15:0] I_MEM_DATA,
   input  wire        I_MEM_ALIGN_ERR,
   input  wire        I_MEM_DSI_ERR,
   output reg         O_READY,
   output reg  [4:0]  O_GPR_RADDR_A,
   output reg  [4:0]  O_GPR_RADDR_B,
   output reg         O_MEM_REQ,
   output reg  [31:0] O_MEM_ADDR,
   output reg         O_GPR_WE,
   output reg  [4:0]  O_GPR_WADDR,
   output reg  [31:0] O_GPR_WDATA,
   output reg         O_DONE,
   output reg         O_ILLEGAL,
   output reg         O_FAULT,
   output reg         O_XER_WE,
   output reg         O_CR0_WE
);

   // Sequencer states
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_READ   = 3'h1;
   localparam [2:0] ST_MEM    = 3'h2;
   localparam [2:0] ST_UPDATE = 3'h3;

   reg  [2:0]  state;
   reg  [4:0]  target_reg_field;
   reg  [4:0]  base_reg_field;
   reg  [15:0] imm;
   reg  [1:0]  ext_kind;
   reg         indexed;
   reg         update;

   reg  [2:0]  next_state;
   reg  [4:0]  next_target_reg_field;
   reg  [4:0]  next_base_reg_field;
   reg  [15:0] next_imm;
   reg  [1:0]  next_ext_kind;
   reg         next_indexed;
   reg         next_update;
   reg         next_ready;
   reg  [4:0]  next_raddr_a;
   reg  [4:0]  next_raddr_b;
   reg         next_mem_req;
   reg  [31:0] next_mem_addr;
   reg         next_gpr_we;
   reg  [4:0]  next_gpr_waddr;
   reg  [31:0] next_gpr_wdata;
   reg         next_done;
   reg         next_illegal;
   reg         next_fault;

   // Decode of the offered word
   wire [5:0]  dec_primary = I_INSN[`PRIMARY_HI:`PRIMARY_LO];
   wire [9:0]  dec_extop   = I_INSN[`EXTOP_HI:`EXTOP_LO];
   wire [4:0]  dec_target  = I_INSN[`TARGET_HI:`TARGET_LO];
   wire [4:0]  dec_base    = I_INSN[`BASE_HI:`BASE_LO];
   wire [4:0]  dec_index   = I_INSN[`INDEX_HI:`INDEX_LO];
   wire [15:0] dec_imm     = I_INSN[`IMM_HI:`IMM_LO];
   reg         dec_legal;
   reg  [1:0]  dec_ext;
   reg         dec_indexed;
   reg         dec_update;

   // Location and result forming
   reg  [31:0] base_term;
   reg  [31:0] offset_term;
   reg  [31:0] access_location;
   reg  [31:0] load_result;
   wire        mem_fault = I_MEM_ALIGN_ERR | I_MEM_DSI_ERR;
   wire        update_ok = update && (base_reg_field != `REG_ZERO) &&
                           (base_reg_field != target_reg_field);
   // Displacement is signed for the unsigned loads as well
   wire [31:0] imm_ext     = {{16{imm[15]}}, imm};

   // Bit 31 of the X forms is ignored: each load has a single form
   always @* begin
      dec_legal   = 1'b1;
      dec_ext     = `EXT_ZERO;
      dec_indexed = 1'b0;
      dec_update  = 1'b0;
      case (dec_primary)
         `OP_UNSIGNED_DISP: begin
            dec_ext = `EXT_ZERO;
         end
         `OP_UNSIGNED_UPD: begin
            dec_ext    = `EXT_ZERO;
            dec_update = 1'b1;
         end
         `OP_INDEXED_GROUP: begin
            dec_indexed = 1'b1;
            case (dec_extop)
               `XO_SIGNED_IDX: begin
                  dec_ext = `EXT_SIGN;
               end
               `XO_SWAPPED_IDX: begin
                  dec_ext = `EXT_SWAP;
               end
               `XO_UNSIGNED_UPD: begin
                  dec_ext    = `EXT_ZERO;
                  dec_update = 1'b1;
               end
               `XO_UNSIGNED_IDX: begin
                  dec_ext    = `EXT_ZERO;
                  dec_update = 1'b0;
               end
               default: begin
                  dec_legal = 1'b0;
               end
            endcase
         end
         default: begin
            dec_legal = 1'b0;
         end
      endcase
   end

   // Base field zero means the value zero, not the register contents
   always @* begin
      if (base_reg_field == `REG_ZERO) begin
         base_term = 32'h00000000;
      end else begin
         base_term = I_GPR_RDATA_A;
      end
      if (indexed) begin
         offset_term = I_GPR_RDATA_B;
      end else begin
         offset_term = imm_ext;
      end
      access_location = base_term + offset_term;
   end

   // Halfword bit 15 is the most significant bit here
   always @* begin
      case (ext_kind)
         `EXT_SIGN: begin
            load_result = {{16{I_MEM_DATA[15]}}, I_MEM_DATA};
         end
         `EXT_SWAP: begin
            load_result = {16'h0000, I_MEM_DATA[7:0], I_MEM_DATA[15:8]};
         end
         default: begin
            load_result = {16'h0000, I_MEM_DATA};
         end
      endcase
   end

   always @* begin
      next_state            = state;
      next_target_reg_field = target_reg_field;
      next_base_reg_field   = base_reg_field;
      next_imm              = imm;
      next_ext_kind         = ext_kind;
      next_indexed          = indexed;
      next_update           = update;
      next_ready            = O_READY;
      next_raddr_a          = O_GPR_RADDR_A;
      next_raddr_b          = O_GPR_RADDR_B;
      next_mem_req          = O_MEM_REQ;
      next_mem_addr         = O_MEM_ADDR;
      next_gpr_we           = 1'b0;
      next_gpr_waddr        = O_GPR_WADDR;
      next_gpr_wdata        = O_GPR_WDATA;
      next_done             = 1'b0;
      next_illegal          = 1'b0;
      next_fault            = 1'b0;
      case (state)
         ST_IDLE: begin
            if (I_INSN_VALID) begin
               if (dec_legal) begin
                  next_target_reg_field = dec_target;
                  next_base_reg_field   = dec_base;
                  next_imm              = dec_imm;
                  next_raddr_a          = dec_base;
                  next_raddr_b          = dec_index;
                  next_ext_kind         = dec_ext;
                  next_indexed          = dec_indexed;
                  next_update           = dec_update;
                  next_ready            = 1'b0;
                  next_state            = ST_READ;
               end else begin
                  // Unknown words are answered at once and not executed
                  next_done    = 1'b1;
                  next_illegal = 1'b1;
               end
            end
         end
         ST_READ: begin
            next_mem_addr = access_location;
            next_mem_req  = 1'b1;
            next_state    = ST_MEM;
         end
         ST_MEM: begin
            if (I_MEM_ACK) begin
               next_mem_req = 1'b0;
               if (mem_fault) begin
                  // Interrupted access leaves every register untouched
                  next_fault = 1'b1;
                  next_done  = 1'b1;
                  next_ready = 1'b1;
                  next_state = ST_IDLE;
               end else begin
                  next_gpr_we    = 1'b1;
                  next_gpr_waddr = target_reg_field;
                  next_gpr_wdata = load_result;
                  if (update_ok) begin
                     next_state = ST_UPDATE;
                  end else begin
                     next_done  = 1'b1;
                     next_ready = 1'b1;
                     next_state = ST_IDLE;
                  end
               end
            end
         end
         ST_UPDATE: begin
            // One write port, so the base write takes its own cycle
            next_gpr_we    = 1'b1;
            next_gpr_waddr = base_reg_field;
            next_gpr_wdata = O_MEM_ADDR;
            next_done      = 1'b1;
            next_ready     = 1'b1;
            next_state     = ST_IDLE;
         end
         default: begin
            next_ready = 1'b1;
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge I_CLK) begin
      if (I_RST) begin
         state            <= ST_IDLE;
         target_reg_field <= 5'h00;
         base_reg_field   <= 5'h00;
         imm              <= 16'h0000;
         ext_kind         <= `EXT_ZERO;
         indexed          <= 1'b0;
         update           <= 1'b0;
         O_READY          <= 1'b1;
         O_GPR_RADDR_A    <= 5'h00;
         O_GPR_RADDR_B    <= 5'h00;
         O_MEM_REQ        <= 1'b0;
         O_MEM_ADDR       <= 32'h00000000;
         O_GPR_WE         <= 1'b0;
         O_GPR_WADDR      <= 5'h00;
         O_GPR_WDATA      <= 32'h00000000;
         O_DONE           <= 1'b0;
         O_ILLEGAL        <= 1'b0;
         O_FAULT          <= 1'b0;
         O_XER_WE         <= 1'b0;
         O_CR0_WE         <= 1'b0;
      end else begin
         state            <= next_state;
         target_reg_field <= next_target_reg_field;
         base_reg_field   <= next_base_reg_field;
         imm              <= next_imm;
         ext_kind         <= next_ext_kind;
         indexed          <= next_indexed;
         update           <= next_update;
         O_READY          <= next_ready;
         O_GPR_RADDR_A    <= next_raddr_a;
         O_GPR_RADDR_B    <= next_raddr_b;
         O_MEM_REQ        <= next_mem_req;
         O_MEM_ADDR       <= next_mem_addr;
         O_GPR_WE         <= next_gpr_we;
         O_GPR_WADDR      <= next_gpr_waddr;
         O_GPR_WDATA      <= next_gpr_wdata;
         O_DONE           <= next_done;
         O_ILLEGAL        <= next_illegal;
         O_FAULT          <= next_fault;
         // These loads never touch exception or condition state
         O_XER_WE         <= 1'b0;
         O_CR0_WE         <= 1'b0;
      end
   end

endmodule

// ===== halfword_load_unit_checker.sv
`timescale 1ns/1ps
module halfword_load_unit_checker (
   input wire        I_CLK,
   input wire        I_RST,
   input wire        I_INSN_VALID,
   input wire [31:0] I_INSN,
   input wire [31:0] I_GPR_RDATA_A,
   input wire [31:0] I_GPR_RDATA_B,
   input wire        I_MEM_ACK,
   input wire [15:0] I_MEM_DATA,
   input wire        I_MEM_ALIGN_ERR,
   input wire        I_MEM_DSI_ERR,
   input wire        O_READY,
   input wire        O_MEM_REQ,
   input wire [31:0] O_MEM_ADDR,
   input wire        O_GPR_WE,
   input wire [4:0]  O_GPR_WADDR,
   input wire [31:0] O_GPR_WDATA,
   input wire        O_DONE,
   input wire        O_ILLEGAL,
   input wire        O_FAULT,
   input wire        O_XER_WE,
   input wire        O_CR0_WE
);
   reg  [31:0] insn;
   reg  [31:0] a;
   reg  [31:0] b;
   reg  [15:0] d;
   reg         rd;
   wire [4:0]  rt  = insn[25:21];
   wire [4:0]  ra  = insn[20:16];
   wire [9:0]  xo  = insn[10:1];
   wire        idx = insn[31:26] == 6'h1F;
   wire        upd = insn[31:26] == 6'h29 || (idx && xo == 10'h14B);
   wire [31:0] off = idx ? b : {{16{insn[15]}}, insn[15:0]};
   wire [31:0] ea  = (ra != 5'h00) ? a + off : off;
   wire [31:0] res = (idx && xo == 10'h157) ? {{16{d[15]}}, d} :
                     (idx && xo == 10'h316) ? {16'h0000, d[7:0], d[15:8]} : {16'h0000, d};
   wire [9:0]  nx  = I_INSN[10:1];
   wire        lgl = I_INSN[31:27] == 5'h14 || (I_INSN[31:26] == 6'h1F &&
                     (nx == 10'h157 || nx == 10'h316 || nx == 10'h117 || nx == 10'h14B));
   wire        ack = O_MEM_REQ && I_MEM_ACK;
   wire        err = I_MEM_ALIGN_ERR || I_MEM_DSI_ERR;
   // Operands captured as the design reads them, one cycle after the take
   always @(posedge I_CLK) begin
      rd <= I_INSN_VALID && O_READY && !I_RST;
      if (I_INSN_VALID && O_READY)
         insn <= I_INSN;
      if (rd) begin
         a <= I_GPR_RDATA_A;
         b <= I_GPR_RDATA_B;
      end
      if (ack)
         d <= I_MEM_DATA;
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   a_flags_untouched: assert property (!O_XER_WE && !O_CR0_WE) else $error("flag write");
   a_illegal_answer: assert property (I_INSN_VALID && O_READY && !lgl |=> O_DONE && O_ILLEGAL && O_READY)
      else $error("undecoded word not refused");
   a_addr_formed: assert property (O_MEM_REQ |-> O_MEM_ADDR == ea) else $error("bad address");
   a_target_value: assert property (O_GPR_WE && O_GPR_WADDR == rt |-> O_GPR_WDATA == res)
      else $error("bad target data");
   a_base_written: assert property (O_GPR_WE && O_GPR_WADDR != rt |-> upd && ra != 5'h00 && O_GPR_WDATA == ea)
      else $error("bad base write");
   a_plain_done: assert property (ack && !err && !upd |=> O_DONE && O_GPR_WE) else $error("plain load late");
   a_update_pair: assert property (ack && !err && upd && ra != 5'h00 && ra != rt |=>
      O_GPR_WE && !O_DONE ##1 O_GPR_WE && O_DONE && O_GPR_WADDR == ra) else $error("update missing");
   a_update_skip: assert property (ack && !err && upd && (ra == 5'h00 || ra == rt) |=>
      O_DONE && O_GPR_WE ##1 !O_GPR_WE) else $error("update not skipped");
   a_fault_quiet: assert property (ack && err |=> O_DONE && O_FAULT && !O_GPR_WE) else $error("fault wrote");
endmodule
bind halfword_load_unit halfword_load_unit_checker halfword_load_unit_checker_inst (.*);

// ===== halfword_load_partner.sv
`timescale 1ns/1ps
module halfword_load_partner (
   input  wire        i_clk,
   input  wire [31:0] i_key,
   input  wire [4:0]  i_raddr_a,
   input  wire [4:0]  i_raddr_b,
   input  wire        i_req,
   input  wire [1:0]  i_delay,
   input  wire [15:0] i_hword,
   input  wire        i_align,
   input  wire        i_dsi,
   output wire [31:0] o_rdata_a,
   output wire [31:0] o_rdata_b,
   output reg         o_ack,
   output reg  [15:0] o_data,
   output reg         o_align,
   output reg         o_dsi
);
   reg [1:0] cnt;
   // Register zero reads as key too, so a design that uses it gets caught
   assign o_rdata_a = i_key ^ {7'h00, {5{i_raddr_a}}};
   assign o_rdata_b = i_key ^ {7'h00, {5{i_raddr_b}}};
   initial begin
      o_ack = 1'b0;
      o_data = 16'h0000;
      o_align = 1'b0;
      o_dsi = 1'b0;
      cnt = 2'h0;
   end
   // Data toggles while idle so a stale value never looks right
   always @(posedge i_clk) begin
      if (o_ack || !i_req) begin
         o_ack <= 1'b0;
         cnt <= 2'h0;
         o_data <= ~o_data;
         o_align <= 1'b0;
         o_dsi <= 1'b0;
      end else if (cnt == i_delay) begin
         o_ack <= 1'b1;
         o_data <= i_hword;
         o_align <= i_align;
         o_dsi <= i_dsi;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule

// ===== tb_halfword_load_unit.sv
`timescale 1ns/1ps
module tb_halfword_load_unit;
   reg         I_CLK = 1'b0;
   reg         I_RST, I_INSN_VALID, al, ds, upd, flt;
   reg  [31:0] I_INSN, key, seed, off, ea, exp;
   reg  [15:0] hw, imm;
   reg  [1:0]  dly;
   reg  [4:0]  rt, ra, rb;
   reg  [4:0]  wa [0:1];
   reg  [31:0] wd [0:1];
   wire [31:0] I_GPR_RDATA_A, I_GPR_RDATA_B, O_MEM_ADDR, O_GPR_WDATA;
   wire [15:0] I_MEM_DATA;
   wire [4:0]  O_GPR_RADDR_A, O_GPR_RADDR_B, O_GPR_WADDR;
   wire        I_MEM_ACK, I_MEM_ALIGN_ERR, I_MEM_DSI_ERR, O_READY, O_MEM_REQ, O_GPR_WE;
   wire        O_DONE, O_ILLEGAL, O_FAULT, O_XER_WE, O_CR0_WE;
   integer     errors, checks_done, i, k, n, t;
   halfword_load_unit halfword_load_unit_inst (.I_CLK(I_CLK), .I_RST(I_RST), .I_INSN_VALID(I_INSN_VALID),
      .I_INSN(I_INSN), .I_GPR_RDATA_A(I_GPR_RDATA_A), .I_GPR_RDATA_B(I_GPR_RDATA_B), .I_MEM_ACK(I_MEM_ACK),
      .I_MEM_DATA(I_MEM_DATA), .I_MEM_ALIGN_ERR(I_MEM_ALIGN_ERR), .I_MEM_DSI_ERR(I_MEM_DSI_ERR),
      .O_READY(O_READY), .O_GPR_RADDR_A(O_GPR_RADDR_A), .O_GPR_RADDR_B(O_GPR_RADDR_B), .O_MEM_REQ(O_MEM_REQ),
      .O_MEM_ADDR(O_MEM_ADDR), .O_GPR_WE(O_GPR_WE), .O_GPR_WADDR(O_GPR_WADDR), .O_GPR_WDATA(O_GPR_WDATA),
      .O_DONE(O_DONE), .O_ILLEGAL(O_ILLEGAL), .O_FAULT(O_FAULT), .O_XER_WE(O_XER_WE), .O_CR0_WE(O_CR0_WE));
   halfword_load_partner halfword_load_partner_inst (.i_clk(I_CLK), .i_key(key), .i_raddr_a(O_GPR_RADDR_A),
      .i_raddr_b(O_GPR_RADDR_B), .i_req(O_MEM_REQ), .i_delay(dly), .i_hword(hw), .i_align(al), .i_dsi(ds),
      .o_rdata_a(I_GPR_RDATA_A), .o_rdata_b(I_GPR_RDATA_B), .o_ack(I_MEM_ACK), .o_data(I_MEM_DATA),
      .o_align(I_MEM_ALIGN_ERR), .o_dsi(I_MEM_DSI_ERR));
   initial begin
      forever #2 I_CLK = ~I_CLK;
   end
   function [31:0] xs(input [31:0] s);
      reg [31:0] v;
      begin
         v = s ^ (s << 13);
         v = v ^ (v >> 17);
         xs = v ^ (v << 5);
      end
   endfunction
   function [31:0] gv(input [4:0] r);
      gv = key ^ {7'h00, {5{r}}};
   endfunction
   task chk(input [31:0] got, input [31:0] want);
      begin
         checks_done = checks_done + 1;
         if (got !== want) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      I_RST = 1'b1; I_INSN_VALID = 1'b0; I_INSN = 32'h0000_0000; key = 32'h0000_0000; hw = 16'h0000;
      dly = 2'h0; al = 1'b0; ds = 1'b0; errors = 0; checks_done = 0; seed = 32'h0000004E;
      repeat (20) @(posedge I_CLK);
      @(negedge I_CLK) I_RST = 1'b0;
      chk(32'({O_READY, O_MEM_REQ, O_GPR_WE, O_DONE, O_XER_WE, O_CR0_WE}), 32'h00000020);
      // First rounds walk every kind, the first seven with a sign bit set; every fifth round has base zero
      for (i = 0; i < 300; i = i + 1) begin
         seed = xs(seed);
         k = (i < 14) ? i % 7 : seed % 7;
         rt = seed[12:8]; rb = seed[22:18];
         ra = (i % 5 == 0) ? 5'h00 : seed[17:13];
         if (i % 7 == 3) rt = ra;
         seed = xs(seed); key = seed;
         seed = xs(seed); hw = (i < 7) ? 16'h8001 : seed[15:0]; dly = seed[17:16];
         al = seed[20:18] == 3'h0; ds = seed[23:21] == 3'h0; imm = seed[31:16];
         I_INSN = k == 4 ? {6'h28, rt, ra, imm} : k == 5 ? {6'h29, rt, ra, imm} : k == 6 ? {6'h00, rt, ra, imm} :
                  {6'h1F, rt, ra, rb, k == 0 ? 10'h157 : k == 1 ? 10'h316 : k == 2 ? 10'h117 : 10'h14B, seed[0]};
         off = (k < 4) ? gv(rb) : {{16{imm[15]}}, imm};
         ea = (ra != 5'h00) ? gv(ra) + off : off;
         exp = k == 0 ? {{16{hw[15]}}, hw} : k == 1 ? {16'h0000, hw[7:0], hw[15:8]} : {16'h0000, hw};
         upd = (k == 3 || k == 5) && ra != 5'h00 && ra != rt;
         flt = (al || ds) && k != 6;
         I_INSN_VALID = 1'b1;
         @(negedge I_CLK) I_INSN_VALID = 1'b0;
         n = 0;
         for (t = 0; t < 20 && O_DONE !== 1'b1; t = t + 1) begin
            @(negedge I_CLK);
            if (O_GPR_WE === 1'b1 && n < 2) begin
               wa[n] = O_GPR_WADDR; wd[n] = O_GPR_WDATA; n = n + 1;
            end
         end
         if (t == 20) begin
            errors = errors + 1;
            i = 300;
         end else begin
            chk(32'(O_ILLEGAL), 32'(k == 6));
            chk(32'(O_FAULT), 32'(flt));
            chk(32'(n), (k == 6 || flt) ? 0 : upd ? 2 : 1);
            chk(32'({O_READY, O_XER_WE, O_CR0_WE}), 32'h00000004);
            if (k != 6) chk(O_MEM_ADDR, ea);
            if (k != 6) chk(32'(O_GPR_RADDR_A), 32'(ra));
            if (k < 4) chk(32'(O_GPR_RADDR_B), 32'(rb));
            if (n > 0) chk(32'(wa[0]), 32'(rt));
            if (n > 0) chk(wd[0], exp);
            if (n > 1) chk(32'(wa[1]), 32'(ra));
            if (n > 1) chk(wd[1], ea);
            $display("test %0d kind %0d done", i, k);
            // Let an edge pass so the valid strobe is not driven twice at once
            if (k == 6) @(negedge I_CLK);
         end
      end
      wrap_up;
   end
endmodule
